// >>> design/kpr_host.sv
// Host capture end: samples the link, rebuilds physical order per kernel.
// Assumes software keeps mode stable while a frame is in flight.
`timescale 1ns/10ps
`include "kpr_consts.svh"
module kpr_host (
   // Link
   kpr_if.host lnk,
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Pixels in physical order
   output logic o_pix_valid,
   output logic [7:0] o_pix_x,
   output logic [1:0] o_pix_line,
   output kpr_pkg::kpr_sample_t o_pix_data,
   // Control port helpers
   input wire logic i_scl_stretch,
   output logic [7:0] o_i2c_wr_addr,
   output logic [7:0] o_i2c_rd_addr,
   output logic o_scl_tick
);
   import kpr_pkg::*;

   // Registers
   logic [2:0] ctrl;
   logic [15:0] region_of_interest;
   logic [7:0] i2c_addr;
   logic [15:0] frames;
   logic overrun;
   wire logic sel_ctrl;
   wire logic sel_roi;
   wire logic sel_i2c;
   wire logic sel_stat;
   wire logic misaligned;
   wire logic odd_start;
   wire logic [31:0] rd_mux;
   assign sel_ctrl = i_wr && i_addr == `KPR_REG_CTRL;
   assign sel_roi = i_wr && i_addr == `KPR_REG_ROI;
   assign sel_i2c = i_wr && i_addr == `KPR_REG_I2C;
   assign sel_stat = i_wr && i_addr == `KPR_REG_STAT;
   // Borders must sit on kernels, merged kernels when subsampling
   assign misaligned = ctrl[`KPR_CTRL_SUB] ? (region_of_interest[3:0] != 4'h0 || region_of_interest[11:8] != 4'h0) :
                       (region_of_interest[2:0] != 3'h0 || region_of_interest[10:8] != 3'h0);
   assign odd_start = region_of_interest[3];

   // Link side: mode levels and captured kernels
   logic [2:0] mode1;
   logic [2:0] mode2;
   logic odd1;
   logic odd2;
   kpr_sample_t kbuf [0:7];
   logic [79:0] kword;
   logic [3:0] kcnt_l;
   logic [3:0] ksent;
   logic [1:0] lcnt_l;
   logic [1:0] lsent;
   logic tog_l;
   logic lv_q;
   kpr_step_t step_l;
   kpr_pos_t pos_l;
   wire logic take;
   wire kpr_sample_t cap;
   wire logic [2:0] slot;
   // Kernel as it stands after this sample lands in its slot
   wire kpr_sample_t kin [0:7];
   assign take = lnk.frame_valid && lnk.line_valid;
   assign cap = mode2[`KPR_CTRL_NARROW] ? {lnk.data[9:2], 2'h0} : lnk.data;
   // Subsampled kernels already arrive in ascending order
   assign slot = mode2[`KPR_CTRL_SUB] ? step_l : pos_l[2:0];

   kpr_kernel_order u_order_link (
      .i_subsample(mode2[`KPR_CTRL_SUB]),
      .i_colour(mode2[`KPR_CTRL_COL]),
      .i_kernel_odd(kcnt_l[0] ^ odd2),
      .i_step(step_l),
      .o_pos(pos_l)
   );

   // Capture on the falling edge, half a period after the data change
   always_ff @(negedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode1 <= 3'h0;
         mode2 <= 3'h0;
         odd1 <= 1'b0;
         odd2 <= 1'b0;
         step_l <= 3'h0;
         kcnt_l <= 4'h0;
         lcnt_l <= 2'h0;
         lv_q <= 1'b0;
         tog_l <= 1'b0;
         kword <= 80'h0;
         ksent <= 4'h0;
         lsent <= 2'h0;
      end else begin
         mode1 <= ctrl;
         mode2 <= mode1;
         odd1 <= odd_start;
         odd2 <= odd1;
         lv_q <= take;
         step_l <= take ? step_l + 3'h1 : 3'h0;
         kcnt_l <= !take ? 4'h0 : (step_l == 3'h7) ? kcnt_l + 4'h1 : kcnt_l;
         lcnt_l <= !lnk.frame_valid ? 2'h0 : (lv_q && !take) ? lcnt_l + 2'h1 : lcnt_l;
         if (take && step_l == 3'h7) begin
            // Hand over only a complete kernel
            kword <= {kin[7], kin[6], kin[5], kin[4], kin[3], kin[2], kin[1], kin[0]};
            ksent <= kcnt_l;
            lsent <= lcnt_l;
            tog_l <= ~tog_l;
         end
      end
   end

   generate
      for (genvar g = 0; g < 8; g++) begin : g_kbuf
         // Odd kernels end on slot 0, so the last sample may land on slot 0 or slot 7
         assign kin[g] = (slot == 3'(g)) ? cap : kbuf[g];
         always_ff @(negedge lnk.pclk or negedge i_nrst) begin
            if (!i_nrst) begin
               kbuf[g] <= 10'h000;
            end else if (take && slot == 3'(g)) begin
               kbuf[g] <= cap;
            end
         end
      end
   endgenerate

   // System side: kernel handover by toggle, drained one pixel a cycle
   logic [2:0] tog_s;
   logic [2:0] fv_s;
   logic [1:0] stretch_s;
   logic [79:0] hold;
   logic [3:0] hkern;
   logic [1:0] hline;
   logic busy;
   kpr_step_t oidx;
   kpr_pos_t pos_o;
   logic [6:0] tick_cnt;
   wire logic arrive;
   wire logic [7:0] kbase;
   wire logic [9:0] oword;
   assign arrive = tog_s[2] ^ tog_s[1];
   assign kbase = region_of_interest[7:0] + (ctrl[`KPR_CTRL_SUB] ? {hkern, 4'h0} : {1'b0, hkern, 3'h0});
   assign oword = hold[10 * oidx +: 10];

   kpr_kernel_order u_order_out (
      .i_subsample(ctrl[`KPR_CTRL_SUB]),
      .i_colour(ctrl[`KPR_CTRL_COL]),
      .i_kernel_odd(1'b0),
      .i_step(oidx),
      .o_pos(pos_o)
   );

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tog_s <= 3'h0;
         fv_s <= 3'h0;
         stretch_s <= 2'h0;
         hold <= 80'h0;
         hkern <= 4'h0;
         hline <= 2'h0;
         busy <= 1'b0;
         oidx <= 3'h0;
         o_pix_valid <= 1'b0;
         o_pix_x <= 8'h00;
         o_pix_line <= 2'h0;
         o_pix_data <= 10'h000;
         overrun <= 1'b0;
         frames <= 16'h0000;
      end else begin
         tog_s <= {tog_s[1:0], tog_l};
         fv_s <= {fv_s[1:0], lnk.frame_valid};
         stretch_s <= {stretch_s[0], i_scl_stretch};
         if (arrive) begin
            hold <= kword;
            hkern <= ksent;
            hline <= lsent;
         end
         busy <= arrive || (busy && oidx != 3'h7);
         oidx <= busy ? oidx + 3'h1 : 3'h0;
         o_pix_valid <= busy;
         o_pix_x <= kbase + {4'h0, pos_o};
         o_pix_line <= hline;
         o_pix_data <= oword;
         // A new kernel landing mid-drain is flagged; set beats clear
         overrun <= (arrive && busy) || (overrun && !(sel_stat && i_wdata[3]));
         frames <= frames + {15'h0000, fv_s[1] && !fv_s[2]};
      end
   end

   // Register writes and delayed read data
   assign rd_mux = (i_addr == `KPR_REG_CTRL) ? {29'h0, ctrl} :
                   (i_addr == `KPR_REG_ROI) ? {16'h0, region_of_interest} :
                   (i_addr == `KPR_REG_STAT) ? {28'h0, overrun, odd_start, misaligned, fv_s[2]} :
                   (i_addr == `KPR_REG_I2C) ? {24'h0, i2c_addr} :
                   (i_addr == `KPR_REG_FRAMES) ? {16'h0, frames} : 32'h0;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= `KPR_CTRL_RESET;
         region_of_interest <= `KPR_ROI_RESET;
         i2c_addr <= `KPR_ADDR_BASE;
         o_rdata <= 32'h0;
         tick_cnt <= 7'h00;
         o_scl_tick <= 1'b0;
      end else begin
         if (sel_ctrl) ctrl <= i_wdata[2:0];
         if (sel_roi) region_of_interest <= i_wdata[15:0];
         if (sel_i2c) i2c_addr <= i_wdata[7:0];
         o_rdata <= i_rd ? rd_mux : 32'h0;
         // Bit clock halts while the device stretches it
         if (!stretch_s[1]) begin
            tick_cnt <= (tick_cnt == 7'(`KPR_I2C_HALF_CYC - 1)) ? 7'h00 : tick_cnt + 7'h01;
         end
         o_scl_tick <= !stretch_s[1] && tick_cnt == 7'(`KPR_I2C_HALF_CYC - 1);
      end
   end

   assign o_i2c_wr_addr = {i2c_addr[7:1], 1'b0};
   assign o_i2c_rd_addr = {i2c_addr[7:1], 1'b1};
endmodule

// >>> design/kpr_consts.svh
// Constants for the kernel pixel readout link: geometry, timing, addresses, host registers.
// Assumes inclusion by bare name from design files only.
`ifndef KPR_CONSTS_SVH
`define KPR_CONSTS_SVH
// Kernel and frame geometry
`define KPR_KERNEL_PIX 8
`define KPR_LINE_KERNELS 4'h8
`define KPR_LINES 2'h3
`define KPR_FV_LEAD 4'h4
`define KPR_LINE_GAP 4'h6
// Sensor control port addresses
`define KPR_ADDR_BASE 8'h90
`define KPR_ADDR_SEL_BIT 3
`define KPR_ADDR_JMP_BIT 5
// Host register offsets
`define KPR_REG_CTRL 4'h0
`define KPR_REG_ROI 4'h1
`define KPR_REG_STAT 4'h2
`define KPR_REG_I2C 4'h3
`define KPR_REG_FRAMES 4'h4
// Host control fields
`define KPR_CTRL_SUB 0
`define KPR_CTRL_COL 1
`define KPR_CTRL_NARROW 2
`define KPR_CTRL_RESET 3'h0
`define KPR_ROI_RESET 16'h4000
// Host I2C timing
`define KPR_CLK_HZ 10000000
`define KPR_I2C_HZ 100000
`define KPR_I2C_MAX_HZ 400000
`define KPR_I2C_HALF_CYC (`KPR_CLK_HZ / (2 * `KPR_I2C_HZ))
`endif

// >>> design/kpr_pkg.sv
// Types shared by both ends of the kernel pixel readout link.
// Assumes kpr_consts.svh for the numeric constants.
package kpr_pkg;
   typedef logic [9:0] kpr_sample_t;
   typedef logic [3:0] kpr_pos_t;
   typedef logic [2:0] kpr_step_t;
   typedef logic [3:0] kpr_kidx_t;
   typedef enum logic [1:0] {KPR_IDLE, KPR_LEAD, KPR_LINE, KPR_GAP} kpr_dev_state_t;
endpackage

// >>> design/kpr_if.sv
// Parallel pixel link between the camera end and the host capture end.
// Assumes the bench drives the free running pixel clock.
`timescale 1ns/10ps
interface kpr_if (
   input wire logic pclk
);
   logic frame_valid;
   logic line_valid;
   logic [9:0] data;
   modport dev (input pclk, output frame_valid, output line_valid, output data);
   modport host (input pclk, input frame_valid, input line_valid, input data);
endinterface

// >>> design/kpr_kernel_order.sv
// Position within a kernel of the n-th sample sent, per readout mode.
// Assumes purely combinational use by either end.
`timescale 1ns/10ps
module kpr_kernel_order (
   // Mode
   input wire logic i_subsample,
   input wire logic i_colour,
   input wire logic i_kernel_odd,
   // Step
   input wire kpr_pkg::kpr_step_t i_step,
   // Position
   output kpr_pkg::kpr_pos_t o_pos
);
   import kpr_pkg::*;
   wire kpr_pos_t pos_even;
   wire kpr_pos_t pos_odd;
   wire kpr_pos_t pos_mono_sub;
   wire kpr_pos_t pos_col_sub;
   assign pos_even = {1'b0, i_step};
   assign pos_odd = {1'b0, 3'h7 - i_step};
   assign pos_mono_sub = {i_step, 1'b0};
   assign pos_col_sub = {i_step[2:1], 1'b0, i_step[0]};
   // Parity is ignored once kernels merge
   assign o_pos = i_subsample ? (i_colour ? pos_col_sub : pos_mono_sub) :
                  (i_kernel_odd ? pos_odd : pos_even);
endmodule

// >>> design/kpr_device.sv
// Camera end: emits frames of pixels in kernel order on the parallel link.
// Assumes all user inputs are asynchronous levels, changed between frames.
`timescale 1ns/10ps
`include "kpr_consts.svh"
module kpr_device (
   // Link
   kpr_if.dev lnk,
   // Reset
   input wire logic i_nrst,
   // Readout control levels
   input wire logic i_run,
   input wire logic i_subsample,
   input wire logic i_colour,
   input wire logic i_wide,
   // Region of interest in kernels
   input wire kpr_pkg::kpr_step_t i_roi_first,
   input wire kpr_pkg::kpr_kidx_t i_roi_kernels,
   // Address straps
   input wire logic i_address_select_pin,
   input wire logic i_addr_jumper,
   // Status
   output logic [7:0] o_i2c_addr,
   output logic o_busy
);
   import kpr_pkg::*;

   // Pin synchronisers
   logic [12:0] sync1;
   logic [12:0] sync2;
   wire logic [12:0] pins;
   wire logic run_s;
   wire logic sub_s;
   wire logic col_s;
   wire logic wide_s;
   wire kpr_step_t first_s;
   wire kpr_kidx_t kern_s;
   wire logic sel_s;
   wire logic jmp_s;

   assign pins = {i_run, i_subsample, i_colour, i_wide, i_roi_first, i_roi_kernels,
                  i_address_select_pin, i_addr_jumper};
   assign run_s = sync2[12];
   assign sub_s = sync2[11];
   assign col_s = sync2[10];
   assign wide_s = sync2[9];
   assign first_s = sync2[8:6];
   assign kern_s = sync2[5:2];
   assign sel_s = sync2[1];
   assign jmp_s = sync2[0];

   always_ff @(posedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1 <= 13'h0000;
         sync2 <= 13'h0000;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   // Control port address from straps
   wire logic [7:0] next_addr;
   assign next_addr = `KPR_ADDR_BASE | (8'(sel_s) << `KPR_ADDR_SEL_BIT) |
                      (8'(jmp_s) << `KPR_ADDR_JMP_BIT);

   always_ff @(posedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_i2c_addr <= `KPR_ADDR_BASE;
      end else begin
         o_i2c_addr <= next_addr;
      end
   end

   // Frame configuration, frozen for a whole frame
   logic cfg_sub;
   logic cfg_col;
   logic cfg_wide;
   kpr_step_t cfg_first;
   kpr_kidx_t cfg_last;
   wire kpr_kidx_t emit_kernels;

   // Merged kernels halve the number sent per line
   assign emit_kernels = sub_s ? {1'b0, kern_s[3:1]} : kern_s;

   // Sequencer
   kpr_dev_state_t state;
   kpr_dev_state_t next_state;
   logic [3:0] cnt;
   logic [1:0] line;
   kpr_kidx_t kern;
   kpr_step_t step;
   wire logic start;
   wire logic lead_done;
   wire logic gap_done;
   wire logic kernel_done;
   wire logic line_done;
   wire logic frame_done;

   assign start = run_s && (emit_kernels != 4'h0);
   assign lead_done = (cnt == `KPR_FV_LEAD - 4'h1);
   assign gap_done = (cnt == `KPR_LINE_GAP - 4'h1);
   assign kernel_done = (step == 3'h7);
   assign line_done = kernel_done && (kern == cfg_last);
   // Line counts up at the end of each gap, so the last gap sees count minus one
   assign frame_done = (line == `KPR_LINES - 2'h1);

   always_comb begin
      next_state = state;
      case (state)
         KPR_IDLE: begin
            if (start) begin
               next_state = KPR_LEAD;
            end
         end
         KPR_LEAD: begin
            if (lead_done) begin
               next_state = KPR_LINE;
            end
         end
         KPR_LINE: begin
            if (line_done) begin
               next_state = KPR_GAP;
            end
         end
         KPR_GAP: begin
            if (gap_done) begin
               next_state = frame_done ? KPR_IDLE : KPR_LINE;
            end
         end
         default: begin
            next_state = KPR_IDLE;
         end
      endcase
   end

   always_ff @(posedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= KPR_IDLE;
         cnt <= 4'h0;
         line <= 2'h0;
         kern <= 4'h0;
         step <= 3'h0;
      end else begin
         state <= next_state;
         cnt <= (state != next_state || state == KPR_LINE) ? 4'h0 : cnt + 4'h1;
         step <= (state == KPR_LINE) ? step + 3'h1 : 3'h0;
         if (state != KPR_LINE) begin
            kern <= 4'h0;
         end else if (kernel_done) begin
            kern <= kern + 4'h1;
         end
         if (state == KPR_IDLE) begin
            line <= 2'h0;
         end else if (state == KPR_GAP && gap_done) begin
            line <= line + 2'h1;
         end
      end
   end

   always_ff @(posedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_sub <= 1'b0;
         cfg_col <= 1'b0;
         cfg_wide <= 1'b1;
         cfg_first <= 3'h0;
         cfg_last <= 4'h0;
      end else if (state == KPR_IDLE && start) begin
         cfg_sub <= sub_s;
         cfg_col <= col_s;
         cfg_wide <= wide_s;
         cfg_first <= first_s;
         cfg_last <= emit_kernels - 4'h1;
      end
   end

   // Sample of the current step
   wire kpr_kidx_t kphys;
   kpr_pos_t pos;
   wire logic [7:0] x;
   wire kpr_sample_t sample;
   wire kpr_sample_t next_data;

   // A merged kernel spans two physical kernels
   assign kphys = {1'b0, cfg_first} + (cfg_sub ? {kern[2:0], 1'b0} : kern);

   kpr_kernel_order u_order (
      .i_subsample(cfg_sub),
      .i_colour(cfg_col),
      .i_kernel_odd(kphys[0]),
      .i_step(step),
      .o_pos(pos)
   );

   assign x = {1'b0, kphys, 3'h0} + {4'h0, pos};
   // Test pattern: colour puts the mosaic phase in the top bits
   assign sample = cfg_col ? {line[0], x[0], x} : {line, x};
   assign next_data = cfg_wide ? sample : {sample[9:2], 2'h0};

   // Outputs change on the rising edge so the host samples mid-cycle
   always_ff @(posedge lnk.pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         lnk.frame_valid <= 1'b0;
         lnk.line_valid <= 1'b0;
         lnk.data <= 10'h000;
      end else begin
         lnk.frame_valid <= (state != KPR_IDLE);
         lnk.line_valid <= (state == KPR_LINE);
         lnk.data <= (state == KPR_LINE) ? next_data : 10'h000;
      end
   end

   assign o_busy = (state != KPR_IDLE);
endmodule

// >>> dv/kpr_link_asserts.sv
// Checker for the kernel pixel readout link wires.
// Assumes instantiation beside the link interface, clocked by the pixel clock.
`timescale 1ns/10ps
module kpr_link_asserts (
   // Link
   input wire logic pclk,
   input wire logic frame_valid,
   input wire logic line_valid,
   input wire logic [9:0] data,
   // Reset
   input wire logic i_nrst
);
   logic [7:0] run_len;
   logic [2:0] lines;
   // Counters, since a line or frame outlasts any short repetition
   always_ff @(posedge pclk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_len <= 8'h00;
         lines <= 3'h0;
      end else begin
         run_len <= line_valid ? run_len + 8'h01 : 8'h00;
         lines <= frame_valid ? lines + 3'(line_valid && run_len == 8'h00) : 3'h0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!i_nrst);
   sequence s_lead;
      !line_valid [*4] ##1 line_valid;
   endsequence
   sequence s_gap;
      !line_valid [*6];
   endsequence
   property p_lv_in_fv;
      line_valid |-> frame_valid;
   endproperty
   a_lv_in_fv: assert property (p_lv_in_fv) else $error("line valid outside frame");
   property p_idle_zero;
      !line_valid |-> data == 10'h000;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("data not zero between lines");
   property p_lead;
      $rose(frame_valid) |-> s_lead;
   endproperty
   a_lead: assert property (p_lead) else $error("line start not 4 cycles after frame");
   property p_gap;
      $fell(line_valid) |-> s_gap;
   endproperty
   a_gap: assert property (p_gap) else $error("line gap shorter than 6");
   property p_line_len;
      $fell(line_valid) |-> run_len[2:0] == 3'h0 && run_len != 8'h00;
   endproperty
   a_line_len: assert property (p_line_len) else $error("line not whole kernels");
   property p_lines;
      $fell(frame_valid) |-> lines == 3'h3;
   endproperty
   a_lines: assert property (p_lines) else $error("frame line count wrong");
   // Subsampled kernels span 16 pixels, so only x[7:4] is shared
   property p_kernel;
      line_valid && run_len[2:0] != 3'h0 |-> data[7:4] == $past(data[7:4]);
   endproperty
   a_kernel: assert property (p_kernel) else $error("kernel mixes pixel blocks");
   property p_line_tag;
      line_valid && run_len != 8'h00 |-> data[9] == $past(data[9]);
   endproperty
   a_line_tag: assert property (p_line_tag) else $error("line tag changed in line");
endmodule

// >>> dv/kernel_pixel_readout_order_bench.sv
// Bench for the kernel pixel readout link: camera end and host end face to face.
// Assumes the package, interface and design modules are compiled first.
`timescale 1ns/10ps
module kernel_pixel_readout_order_bench;
   import kpr_pkg::*;
   typedef struct packed {
      logic sub;
      logic col;
      logic wide;
      logic [2:0] first;
      logic [3:0] kern;
   } kpr_row_t;
   // Odd starts, odd counts and 8-bit samples on purpose
   // Merged kernels start on even kernels; the last row leaves an odd start
   kpr_row_t rows [6] = '{'{1'b0, 1'b0, 1'b1, 3'h0, 4'h8}, '{1'b1, 1'b1, 1'b0, 3'h2, 4'h2},
      '{1'b1, 1'b0, 1'b1, 3'h2, 4'h4}, '{1'b1, 1'b1, 1'b1, 3'h0, 4'h6},
      '{1'b0, 1'b0, 1'b0, 3'h0, 4'h2}, '{1'b0, 1'b1, 1'b1, 3'h1, 4'h3}};
   logic [7:0] addrs [4] = '{8'h90, 8'h98, 8'hB0, 8'hB8};
   logic i_clk, pclk, i_nrst, i_run, i_subsample, i_colour, i_wide, i_scl_stretch;
   logic i_address_select_pin, i_addr_jumper, i_wr, i_rd, o_busy, o_pix_valid, o_scl_tick;
   kpr_step_t i_roi_first;
   kpr_kidx_t i_roi_kernels;
   logic [3:0] i_addr;
   logic [31:0] i_wdata, o_rdata, rd;
   logic [7:0] o_i2c_addr, o_pix_x, o_i2c_wr_addr, o_i2c_rd_addr;
   logic [1:0] o_pix_line;
   kpr_sample_t o_pix_data;
   logic [19:0] pq [$];
   int fail_count, n_tests, n;
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Offset start so the two clocks never share an edge
   initial begin
      pclk = 1'b0;
      #37;
      forever #80 pclk = ~pclk;
   end
   kpr_if u_kpr_if (.pclk(pclk));
   kpr_device u_kpr_device (.lnk(u_kpr_if), .i_nrst(i_nrst), .i_run(i_run),
      .i_subsample(i_subsample), .i_colour(i_colour), .i_wide(i_wide),
      .i_roi_first(i_roi_first), .i_roi_kernels(i_roi_kernels),
      .i_address_select_pin(i_address_select_pin), .i_addr_jumper(i_addr_jumper),
      .o_i2c_addr(o_i2c_addr), .o_busy(o_busy));
   kpr_host u_kpr_host (.lnk(u_kpr_if), .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_pix_valid(o_pix_valid), .o_pix_x(o_pix_x), .o_pix_line(o_pix_line),
      .o_pix_data(o_pix_data), .i_scl_stretch(i_scl_stretch),
      .o_i2c_wr_addr(o_i2c_wr_addr), .o_i2c_rd_addr(o_i2c_rd_addr), .o_scl_tick(o_scl_tick));
   kpr_link_asserts u_kpr_link_asserts (.pclk(u_kpr_if.pclk),
      .frame_valid(u_kpr_if.frame_valid), .line_valid(u_kpr_if.line_valid),
      .data(u_kpr_if.data), .i_nrst(i_nrst));
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pix(input logic [19:0] got, input logic [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: pixel %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
      @(posedge i_clk);
   endtask
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge i_clk);
         #1;
         c++;
      end while (o_scl_tick !== 1'b1 && c < 200);
   endtask
   function automatic logic [9:0] pix_exp(input logic col, input logic wide,
         input logic [7:0] x, input logic [1:0] ln);
      logic [9:0] s;
      s = col ? {ln[0], x[0], x} : {ln, x};
      return wide ? s : (s & 10'h3FC);
   endfunction
   // Expected pixels in physical order, then one frame through the link
   task automatic run_row(input kpr_row_t r);
      int klink, pos, c;
      logic [7:0] x;
      klink = r.sub ? r.kern / 2 : r.kern;
      for (int ln = 0; ln < 3; ln++) begin
         for (int k = 0; k < klink; k++) begin
            for (int i = 0; i < 8; i++) begin
               pos = !r.sub ? i : (!r.col ? 2 * i : (i / 2) * 4 + i % 2);
               x = 8'(r.first * 8 + k * (r.sub ? 16 : 8) + pos);
               pq.push_back({2'(ln), x, pix_exp(r.col, r.wide, x, 2'(ln))});
            end
         end
      end
      i_subsample <= r.sub;
      i_colour <= r.col;
      i_wide <= r.wide;
      i_roi_first <= r.first;
      i_roi_kernels <= r.kern;
      reg_wr(4'h0, {29'h0, ~r.wide, r.col, r.sub});
      reg_wr(4'h1, {16'h0, 1'b0, r.kern, 3'h0, 2'h0, r.first, 3'h0});
      i_run <= 1'b1;
      for (c = 0; c < 300 && o_busy !== 1'b1; c++) @(posedge i_clk);
      i_run <= 1'b0;
      for (c = 0; c < 2000 && o_busy !== 1'b0; c++) @(posedge i_clk);
      repeat (40) @(posedge i_clk);
      chk32(pq.size(), 32'h0);
   endtask
   // Sampled mid-cycle, clear of the edge that launches the pixel
   always @(negedge i_clk) begin
      if (o_pix_valid === 1'b1) begin
         chk_pix({o_pix_line, o_pix_x, o_pix_data}, pq.size() > 0 ? pq.pop_front() : 20'hFFFFF);
      end
   end
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      fail_count++;
      results();
   end
   initial begin
      {i_nrst, i_run, i_subsample, i_colour, i_wide, i_scl_stretch} = 6'h00;
      {i_address_select_pin, i_addr_jumper, i_wr, i_rd} = 4'h0;
      i_roi_first = 3'h0;
      i_roi_kernels = 4'h8;
      i_addr = 4'h0;
      i_wdata = 32'h0;
      repeat (2) @(posedge i_clk);
      #1;
      chk32({24'h0, o_i2c_addr}, 32'h90);
      chk32({o_rdata[30:0], o_pix_valid}, 32'h0);
      @(posedge i_clk);
      i_nrst <= 1'b1;
      $display("test reset done");
      reg_rd(4'h0, rd);
      chk32(rd, 32'h0);
      reg_rd(4'h1, rd);
      chk32(rd, 32'h4000);
      reg_rd(4'h3, rd);
      chk32(rd, 32'h90);
      reg_rd(4'hF, rd);
      chk32(rd, 32'h0);
      chk32({16'h0, o_i2c_wr_addr, o_i2c_rd_addr}, 32'h9091);
      $display("test registers done");
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("test row %0d done", i);
      end
      reg_rd(4'h4, rd);
      chk32(rd, 32'h6);
      reg_rd(4'h2, rd);
      chk32(rd & 32'h7, 32'h4);
      reg_wr(4'h1, 32'h1003);
      reg_rd(4'h2, rd);
      chk32(rd & 32'h2, 32'h2);
      $display("test status done");
      for (int s = 0; s < 4; s++) begin
         i_address_select_pin <= s[0];
         i_addr_jumper <= s[1];
         repeat (6) @(posedge i_clk);
         chk32({24'h0, o_i2c_addr}, {24'h0, addrs[s]});
      end
      $display("test straps done");
      wait_tick(n);
      wait_tick(n);
      chk32(n, 32'd50);
      @(posedge i_clk);
      i_scl_stretch <= 1'b1;
      repeat (4) @(posedge i_clk);
      wait_tick(n);
      chk32(n, 32'd200);
      $display("test bit timing done");
      results();
   end
endmodule
